// file: inc/wdt_pkg.sv
// package: register map, field positions, reset values and timing of the watchdog
package wdt_pkg;

   localparam int ADDR_W = 12;

   // printed special-register offsets are kept as indices; byte address is four times the index
   localparam logic [7:0] SUPERVISOR_CONTROL_IDX = 8'hD8;
   localparam logic [7:0] CLOCK_CONTROL_IDX = 8'h8E;
   localparam logic [7:0] EXTENDED_IRQ_ENABLE_IDX = 8'hE8;
   localparam logic [ADDR_W-1:0] SUPERVISOR_CONTROL_ADDR = {2'h0, SUPERVISOR_CONTROL_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] CLOCK_CONTROL_ADDR = {2'h0, CLOCK_CONTROL_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] EXTENDED_IRQ_ENABLE_ADDR = {2'h0, EXTENDED_IRQ_ENABLE_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] POWER_MODE_ADDR = 12'h400;
   localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 12'h404;
   localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 12'h408;

   // supervisor_control_reg fields
   localparam int RESTART_BIT = 0;
   localparam int RESET_ENABLE_BIT = 1;
   localparam int RESET_CAUSE_BIT = 2;
   localparam int TIMEOUT_FLAG_BIT = 3;
   // clock_control_reg fields
   localparam int INTERVAL_SELECT_LO_BIT = 6;
   localparam int INTERVAL_SELECT_HI_BIT = 7;
   // extended_irq_enable_reg field
   localparam int TIMEOUT_IRQ_ENABLE_BIT = 4;
   // power_mode_reg fields: {multiplier_sel, clock_divide_sel}
   localparam int CLOCK_DIVIDE_SEL_LSB = 0;
   localparam int MULTIPLIER_SEL_BIT = 2;
   // irq status / mask fields
   localparam int IRQ_TIMEOUT_BIT = 0;
   localparam int IRQ_WDT_RESET_BIT = 1;

   localparam logic [1:0] INTERVAL_SELECT_RESET = 2'h0;
   localparam logic [2:0] CLOCK_MODE_RESET = 3'h1;
   localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

   // system clock modes {multiplier_sel, clock_divide_sel}
   localparam logic [2:0] MODE_MULT_4X = 3'h4;
   localparam logic [2:0] MODE_MULT_2X = 3'h0;
   localparam logic [1:0] DIVIDE_POWER_MGMT = 2'h3;

   // timeout exponents, in oscillator clocks, for interval code 00
   localparam logic [5:0] OSC_EXP_4X = 6'd15;
   localparam logic [5:0] OSC_EXP_2X = 6'd16;
   localparam logic [5:0] OSC_EXP_DIV1 = 6'd17;
   localparam logic [5:0] OSC_EXP_PMM = 6'd27;
   localparam logic [5:0] EXP_STEP = 6'd3;
   // log2 of system clocks per oscillator clock, offset by this bias
   localparam logic [5:0] SYS_SHIFT_BIAS = 6'd10;
   localparam logic [5:0] SYS_SHIFT_4X = 6'd12;
   localparam logic [5:0] SYS_SHIFT_2X = 6'd11;
   localparam logic [5:0] SYS_SHIFT_DIV1 = 6'd10;
   localparam logic [5:0] SYS_SHIFT_PMM = 6'd0;
   // shortest interval in system clocks, same in every mode
   localparam logic [5:0] SYS_EXP_NOMINAL = 6'd17;

   localparam int COUNT_W = 27;
   localparam int TIMEOUT_TO_RESET_CYCLES = 512;
   localparam int RESET_HOLD_OSC_CYCLES = 13;
   localparam int PMM_OSC_PER_SYS = 1024;
   localparam int HOLD_W = 6;
   localparam logic [9:0] DELAY_LAST = 10'(TIMEOUT_TO_RESET_CYCLES - 1);
   // hold length in system clocks, rounded up, never below one
   localparam logic [HOLD_W-1:0] HOLD_4X = HOLD_W'(RESET_HOLD_OSC_CYCLES * 4);
   localparam logic [HOLD_W-1:0] HOLD_2X = HOLD_W'(RESET_HOLD_OSC_CYCLES * 2);
   localparam logic [HOLD_W-1:0] HOLD_DIV1 = HOLD_W'(RESET_HOLD_OSC_CYCLES);
   localparam logic [HOLD_W-1:0] HOLD_PMM =
      HOLD_W'((RESET_HOLD_OSC_CYCLES + PMM_OSC_PER_SYS - 1) / PMM_OSC_PER_SYS);

   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_DELAY = 3'b010,
      ST_HOLD = 3'b100
   } wdt_state_e;

endpackage

// file: core/cpu_watchdog_timer.sv
// cpu watchdog timer with an apb register slave
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
// Function
// - free-running counter on the system clock, selectable tap sets timeout interval
// - timeout sets flag; timeout_irq_req only with watchdog and global enables set; irq needs only its mask bit
// - writing restart restarts count; hardware clears the restart bit
// - reset cpu 512 system clocks after timeout unless restarted, if enabled
// - watchdog reset sets reset-cause flag, kept until software clears it
// - with reset and interrupt off, flag still set every interval
// - timeout flag cleared only by software write or any reset
// - reset and interrupt enabled independently in any combination
// - two-bit interval field in the clock control register
// - timeout in oscillator clocks depends on system clock mode
// - 4x and 2x mode timeouts in oscillator clocks
// - divide-by-1 and power-management timeouts in oscillator clocks
// - watchdog reset lasts 13 oscillator cycles; one system clock (1024 oscillator cycles) in power-management mode
// - control register bits: restart, reset enable, cause flag, timeout flag
module cpu_watchdog_timer
   import wdt_pkg::*;
#(
   // exponent of the shortest interval in system clocks; lower it to shorten simulation
   parameter logic [5:0] sys_exp_base = 6'd17
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic global_irq_enable,
   output logic timeout_irq_req,
   output logic irq,
   output logic cpu_reset_req
);

   typedef struct packed {
      wdt_state_e state;
      logic [COUNT_W-1:0] count;
      logic [9:0] delay;
      logic [HOLD_W-1:0] hold;
      logic cpu_reset;
      logic restart_bit;
      logic reset_enable_bit;
      logic reset_cause_flag;
      logic timeout_flag;
      logic timeout_irq_enable;
      logic [1:0] interval_select;
      logic [2:0] clock_mode;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      logic [31:0] rdata;
   } wdt_s;

   wdt_s cur;
   wdt_s next_cur;

   // counter tap in system clocks for a clock mode and interval code
   function automatic logic [5:0] interval_tap(input logic [2:0] mode, input logic [1:0] sel);
      logic [5:0] osc_exp;
      logic [5:0] shift;
      osc_exp = OSC_EXP_DIV1;
      shift = SYS_SHIFT_DIV1;
      if (mode[1:0] == DIVIDE_POWER_MGMT) begin
         osc_exp = OSC_EXP_PMM;
         shift = SYS_SHIFT_PMM;
      end else if (mode == MODE_MULT_4X) begin
         osc_exp = OSC_EXP_4X;
         shift = SYS_SHIFT_4X;
      end else if (mode == MODE_MULT_2X) begin
         osc_exp = OSC_EXP_2X;
         shift = SYS_SHIFT_2X;
      end
      // every mode lands on the same system-clock exponent; the bias keeps it positive
      return 6'(osc_exp + EXP_STEP * {4'h0, sel} + shift - SYS_SHIFT_BIAS
                - SYS_EXP_NOMINAL + sys_exp_base);
   endfunction

   // watchdog reset length in system clocks for a clock mode
   function automatic logic [HOLD_W-1:0] hold_cycles(input logic [2:0] mode);
      logic [HOLD_W-1:0] n;
      n = HOLD_DIV1;
      if (mode[1:0] == DIVIDE_POWER_MGMT) begin
         n = HOLD_PMM;
      end else if (mode == MODE_MULT_4X) begin
         n = HOLD_4X;
      end else if (mode == MODE_MULT_2X) begin
         n = HOLD_2X;
      end
      return n;
   endfunction

   logic [5:0] tap;
   logic [COUNT_W-1:0] terminal;
   logic timeout;
   logic wr;
   logic setup;
   logic mapped;

   assign tap = interval_tap(cur.clock_mode, cur.interval_select);
   assign terminal = (COUNT_W'(1) << tap) - COUNT_W'(1);
   assign timeout = (cur.count == terminal);
   assign wr = psel && penable && pwrite;
   assign setup = psel && !penable;
   assign mapped = (paddr == SUPERVISOR_CONTROL_ADDR) || (paddr == CLOCK_CONTROL_ADDR)
                   || (paddr == EXTENDED_IRQ_ENABLE_ADDR) || (paddr == POWER_MODE_ADDR)
                   || (paddr == IRQ_STATUS_ADDR) || (paddr == IRQ_MASK_ADDR);

   // zero-wait slave; read data is captured in the setup cycle
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = cur.rdata;
   assign cpu_reset_req = cur.cpu_reset;
   assign timeout_irq_req = cur.timeout_flag && cur.timeout_irq_enable
                            && global_irq_enable;
   assign irq = |(cur.irq_status & cur.irq_mask);

   always_comb begin
      logic [1:0] irq_set;
      logic fire;
      irq_set = 2'h0;
      fire = 1'b0;
      next_cur = cur;

      // free-running count; a taken restart starts it over
      if (cur.restart_bit || timeout) begin
         next_cur.count = '0;
      end else begin
         next_cur.count = COUNT_W'(cur.count + COUNT_W'(1));
      end
      // restart is taken one edge after the write, then self-clears
      next_cur.restart_bit = 1'b0;

      case (cur.state)
         ST_RUN: begin
            if (timeout && !cur.restart_bit) begin
               next_cur.state = ST_DELAY;
               next_cur.delay = '0;
            end
         end
         ST_DELAY: begin
            if (cur.restart_bit) begin
               next_cur.state = ST_RUN;
            end else if (cur.delay == DELAY_LAST) begin
               if (cur.reset_enable_bit) begin
                  fire = 1'b1;
                  next_cur.state = ST_HOLD;
                  next_cur.hold = hold_cycles(cur.clock_mode);
               end else begin
                  next_cur.state = ST_RUN;
               end
            end else begin
               next_cur.delay = 10'(cur.delay + 10'h001);
            end
         end
         ST_HOLD: begin
            if (cur.hold == HOLD_W'(1)) begin
               next_cur.state = ST_RUN;
            end else begin
               next_cur.hold = HOLD_W'(cur.hold - HOLD_W'(1));
            end
         end
         default: begin
            next_cur.state = ST_RUN;
         end
      endcase
      next_cur.cpu_reset = (next_cur.state == ST_HOLD);

      // register writes
      if (wr) begin
         if (paddr == SUPERVISOR_CONTROL_ADDR) begin
            next_cur.restart_bit = pwdata[RESTART_BIT];
            next_cur.reset_enable_bit = pwdata[RESET_ENABLE_BIT];
            next_cur.reset_cause_flag = pwdata[RESET_CAUSE_BIT];
            next_cur.timeout_flag = pwdata[TIMEOUT_FLAG_BIT];
         end else if (paddr == CLOCK_CONTROL_ADDR) begin
            next_cur.interval_select = pwdata[INTERVAL_SELECT_HI_BIT:INTERVAL_SELECT_LO_BIT];
         end else if (paddr == EXTENDED_IRQ_ENABLE_ADDR) begin
            next_cur.timeout_irq_enable = pwdata[TIMEOUT_IRQ_ENABLE_BIT];
         end else if (paddr == POWER_MODE_ADDR) begin
            next_cur.clock_mode = pwdata[MULTIPLIER_SEL_BIT:CLOCK_DIVIDE_SEL_LSB];
         end else if (paddr == IRQ_STATUS_ADDR) begin
            next_cur.irq_status = cur.irq_status & ~pwdata[1:0];
         end else if (paddr == IRQ_MASK_ADDR) begin
            next_cur.irq_mask = pwdata[1:0];
         end
      end

      // hardware sets win over a clearing write in the same cycle
      if (timeout && !cur.restart_bit) begin
         next_cur.timeout_flag = 1'b1;
         irq_set[IRQ_TIMEOUT_BIT] = 1'b1;
      end
      if (fire) begin
         // the watchdog reset is a reset of the core: flag, enable and count clear
         next_cur.timeout_flag = 1'b0;
         next_cur.reset_enable_bit = 1'b0;
         next_cur.count = '0;
         next_cur.reset_cause_flag = 1'b1;
         irq_set[IRQ_WDT_RESET_BIT] = 1'b1;
      end
      next_cur.irq_status = next_cur.irq_status | irq_set;

      // read data captured in the setup phase from the current state
      if (setup && !pwrite) begin
         next_cur.rdata = 32'h0000_0000;
         if (paddr == SUPERVISOR_CONTROL_ADDR) begin
            next_cur.rdata[RESTART_BIT] = cur.restart_bit;
            next_cur.rdata[RESET_ENABLE_BIT] = cur.reset_enable_bit;
            next_cur.rdata[RESET_CAUSE_BIT] = cur.reset_cause_flag;
            next_cur.rdata[TIMEOUT_FLAG_BIT] = cur.timeout_flag;
         end else if (paddr == CLOCK_CONTROL_ADDR) begin
            next_cur.rdata[INTERVAL_SELECT_HI_BIT:INTERVAL_SELECT_LO_BIT] = cur.interval_select;
         end else if (paddr == EXTENDED_IRQ_ENABLE_ADDR) begin
            next_cur.rdata[TIMEOUT_IRQ_ENABLE_BIT] = cur.timeout_irq_enable;
         end else if (paddr == POWER_MODE_ADDR) begin
            next_cur.rdata[MULTIPLIER_SEL_BIT:CLOCK_DIVIDE_SEL_LSB] = cur.clock_mode;
         end else if (paddr == IRQ_STATUS_ADDR) begin
            next_cur.rdata[1:0] = cur.irq_status;
         end else if (paddr == IRQ_MASK_ADDR) begin
            next_cur.rdata[1:0] = cur.irq_mask;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cur.state <= ST_RUN;
         cur.count <= '0;
         cur.delay <= '0;
         cur.hold <= '0;
         cur.cpu_reset <= 1'b0;
         cur.restart_bit <= 1'b0;
         cur.reset_enable_bit <= 1'b0;
         cur.reset_cause_flag <= 1'b0;
         cur.timeout_flag <= 1'b0;
         cur.timeout_irq_enable <= 1'b0;
         cur.interval_select <= INTERVAL_SELECT_RESET;
         cur.clock_mode <= CLOCK_MODE_RESET;
         cur.irq_status <= 2'h0;
         cur.irq_mask <= IRQ_MASK_RESET;
         cur.rdata <= 32'h0000_0000;
      end else begin
         cur <= next_cur;
      end
   end

endmodule

// file: tb/cpu_watchdog_timer_chk.sv
// port checker for the watchdog: apb answers, interrupt gate and cpu reset timing
`timescale 1ns/100ps
module cpu_watchdog_timer_chk
   import wdt_pkg::*;
#(
   parameter logic [5:0] sys_exp_base = 6'd17
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic global_irq_enable,
   input wire logic timeout_irq_req,
   input wire logic irq,
   input wire logic cpu_reset_req
);
   typedef struct packed {
      logic [2:0] mode;
      logic [HOLD_W-1:0] hold;
   } chk_s;
   chk_s st;
   chk_s next_st;
   logic wr_acc;
   logic rs_wr;
   logic mapped;
   logic [HOLD_W-1:0] hold_exp;
   assign wr_acc = psel && penable && pwrite;
   assign rs_wr = wr_acc && paddr == SUPERVISOR_CONTROL_ADDR && pwdata[RESTART_BIT];
   assign mapped = paddr inside {SUPERVISOR_CONTROL_ADDR, CLOCK_CONTROL_ADDR,
      EXTENDED_IRQ_ENABLE_ADDR, POWER_MODE_ADDR, IRQ_STATUS_ADDR, IRQ_MASK_ADDR};
   // hold length follows the clock mode last written over the bus
   assign hold_exp = st.mode == MODE_MULT_4X ? HOLD_4X : st.mode == MODE_MULT_2X ? HOLD_2X :
      st.mode[1:0] == DIVIDE_POWER_MGMT ? HOLD_PMM : HOLD_DIV1;
   always_comb begin
      next_st = st;
      if (wr_acc && paddr == POWER_MODE_ADDR) begin
         next_st.mode = pwdata[2:0];
      end
      next_st.hold = cpu_reset_req ? st.hold + 1'b1 : '0;
   end
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st <= {CLOCK_MODE_RESET, HOLD_W'(0)};
      end else begin
         st <= next_st;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_restart_settled;
      rs_wr ##1 !cpu_reset_req [*2];
   endsequence
   a_ready_const: assert property (psel && penable |-> pready) else $error("pready low");
   a_err_unmapped: assert property (pslverr == (psel && penable && !mapped))
      else $error("pslverr wrong");
   a_unmapped_zero: assert property (psel && penable && !pwrite && !mapped |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_irq_gate: assert property (timeout_irq_req |-> global_irq_enable)
      else $error("interrupt without global enable");
   a_reset_quiet: assert property ($rose(resetn) |-> !cpu_reset_req && !irq && !timeout_irq_req)
      else $error("outputs active after reset");
   a_restart_noreset: assert property (s_restart_settled |-> (!cpu_reset_req) [*8])
      else $error("reset after restart");
   a_hold_length: assert property ($fell(cpu_reset_req) |-> st.hold == hold_exp)
      else $error("reset hold length wrong");
   a_hold_bound: assert property ($rose(cpu_reset_req) |-> ##[1:52] !cpu_reset_req)
      else $error("reset hold too long");
   a_restart_reads0: assert property (psel && penable && !pwrite &&
      paddr == SUPERVISOR_CONTROL_ADDR && !$past(rs_wr) && !$past(rs_wr, 2) &&
      !$past(rs_wr, 3) |-> !prdata[RESTART_BIT]) else $error("restart bit reads one");
endmodule
bind cpu_watchdog_timer cpu_watchdog_timer_chk #(.sys_exp_base(sys_exp_base)) chk_i (
   .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .global_irq_enable(global_irq_enable), .timeout_irq_req(timeout_irq_req), .irq(irq),
   .cpu_reset_req(cpu_reset_req));

// file: tb/cpu_watchdog_timer_tb.sv
// self-checking bench for the watchdog: intervals, interrupts, cpu reset, apb map
`timescale 1ns/100ps
module cpu_watchdog_timer_tb
   import wdt_pkg::*;
;
   localparam logic [5:0] BASE = 6'd4;
   logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic global_irq_enable = 1'b0, err, pready, pslverr;
   logic timeout_irq_req, irq, cpu_reset_req;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rdv;
   logic [2:0] mode;
   int n_mismatch = 0, tests_run = 0, cyc = 0, n_rst = 0, n, m, h;
   initial begin
      forever #2 clk = ~clk;
   end
   cpu_watchdog_timer #(.sys_exp_base(BASE)) DUT (.clk(clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .global_irq_enable(global_irq_enable),
      .timeout_irq_req(timeout_irq_req), .irq(irq), .cpu_reset_req(cpu_reset_req));
   task automatic complete_run;
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %0h seen %0h", s, e, g);
      end
   endtask
   // counts may land one edge either side of the nominal figure
   task automatic near(input string s, input int e, input int g);
      chk(s, e, (g >= e - 1 && g <= e + 1) ? e : g);
   endtask
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && k < 20) begin
         k++;
         @(posedge clk);
      end
      // a slave that never answers must not pass silently
      chk("pready", 32'h1, {31'h0, pready});
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge clk);
   endtask
   task automatic wait_for(input logic rs, input int lim, output int c);
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while ((rs ? cpu_reset_req : timeout_irq_req) !== 1'b1 && c < lim);
   endtask
   // interval first, then a double restart so a timeout racing the first is wiped
   task automatic restart(input logic [1:0] code);
      apb(1'b1, CLOCK_CONTROL_ADDR, {24'h0, code, 6'h0});
      apb(1'b1, SUPERVISOR_CONTROL_ADDR, 32'h1);
      apb(1'b1, SUPERVISOR_CONTROL_ADDR, 32'h1);
   endtask
   function automatic int hold_of(input logic [2:0] md);
      if (md == MODE_MULT_4X) return RESET_HOLD_OSC_CYCLES * 4;
      if (md == MODE_MULT_2X) return RESET_HOLD_OSC_CYCLES * 2;
      if (md[1:0] == DIVIDE_POWER_MGMT) return 1;
      return RESET_HOLD_OSC_CYCLES;
   endfunction
   always @(posedge clk) begin
      cyc++;
      if (cpu_reset_req === 1'b1) n_rst++;
      if (cyc == 40000) begin
         n_mismatch++;
         complete_run;
      end
   end
   initial begin
      n = $urandom(32'h6fd9cae1);
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      global_irq_enable <= 1'b1;
      apb(1'b0, SUPERVISOR_CONTROL_ADDR, 32'h0);
      chk("supervisor reset", 32'h0, rdv);
      apb(1'b0, IRQ_STATUS_ADDR, 32'h0);
      chk("status reset", 32'h0, rdv);
      apb(1'b0, POWER_MODE_ADDR, 32'h0);
      chk("mode reset", {29'h0, CLOCK_MODE_RESET}, rdv);
      apb(1'b0, CLOCK_CONTROL_ADDR, 32'h0);
      chk("interval reset", 32'h0, rdv);
      apb(1'b0, 12'h7FC, 32'h0);
      chk("unmapped", 32'h1, {rdv[30:0], err});
      apb(1'b1, EXTENDED_IRQ_ENABLE_ADDR, 32'h1 << TIMEOUT_IRQ_ENABLE_BIT);
      for (int c = 0; c < 4; c++) begin
         mode = 3'($urandom);
         apb(1'b1, POWER_MODE_ADDR, {29'h0, mode});
         restart(2'(c));
         wait_for(1'b0, 9000, n);
         near("interval", (1 << (BASE + 3 * c)) + 2, n);
      end
      chk("reset while disabled", 32'h0, n_rst);
      apb(1'b0, SUPERVISOR_CONTROL_ADDR, 32'h0);
      chk("flag read", 32'h8, rdv);
      chk("irq masked", 32'h0, irq);
      @(posedge clk);
      global_irq_enable <= 1'b0;
      @(negedge clk);
      chk("global gate", 32'h0, timeout_irq_req);
      @(posedge clk);
      global_irq_enable <= 1'b1;
      apb(1'b1, EXTENDED_IRQ_ENABLE_ADDR, 32'h0);
      chk("enable gate", 32'h0, timeout_irq_req);
      apb(1'b1, EXTENDED_IRQ_ENABLE_ADDR, 32'h1 << TIMEOUT_IRQ_ENABLE_BIT);
      apb(1'b1, IRQ_MASK_ADDR, 32'h1);
      chk("irq unmasked", 32'h1, irq);
      apb(1'b1, IRQ_STATUS_ADDR, 32'h1);
      chk("irq cleared", 32'h0, irq);
      chk("flag kept", 32'h1, timeout_irq_req);
      apb(1'b1, SUPERVISOR_CONTROL_ADDR, 32'h0);
      chk("flag cleared", 32'h0, timeout_irq_req);
      restart(2'h0);
      apb(1'b1, SUPERVISOR_CONTROL_ADDR, 32'h2);
      wait_for(1'b0, 100, n);
      wait_for(1'b1, 700, m);
      near("reset delay", TIMEOUT_TO_RESET_CYCLES + 1, m);
      h = 0;
      while (cpu_reset_req === 1'b1 && h < 100) begin
         @(posedge clk);
         h++;
      end
      chk("hold", hold_of(mode), h);
      apb(1'b0, SUPERVISOR_CONTROL_ADDR, 32'h0);
      chk("cause set", 32'h4, rdv & 32'h7);
      apb(1'b0, IRQ_STATUS_ADDR, 32'h0);
      chk("reset event", 32'h2, rdv & 32'h2);
      repeat (200) @(posedge clk);
      apb(1'b0, SUPERVISOR_CONTROL_ADDR, 32'h0);
      chk("cause kept", 32'h4, rdv & 32'h4);
      apb(1'b1, SUPERVISOR_CONTROL_ADDR, 32'h0);
      restart(2'h2);
      apb(1'b1, SUPERVISOR_CONTROL_ADDR, 32'h2);
      wait_for(1'b0, 1100, n);
      repeat (200) @(posedge clk);
      m = n_rst;
      apb(1'b1, SUPERVISOR_CONTROL_ADDR, 32'h3);
      repeat (900) @(posedge clk);
      chk("reset cancelled", m, n_rst);
      complete_run;
   end
endmodule
